// file: sim/rsc_core_monitor.sv
// Purpose: Timing checks for push and relative call
// Assumes: Instruction fetched on the Q4 edge, runs next cycle
// Notes: Stimulus keeps the slot after a call idle
`timescale 1ns/10ps
module rsc_core_monitor #(parameter int PC_W = 21) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Inputs
    input wire rsc_pkg::rsc_fetch_s fetch,
    input wire logic top_wr,
    input wire logic [PC_W-1:0] top_wdata,
    // Outputs
    input wire logic [PC_W-1:0] pc_q,
    input wire logic [PC_W-1:0] stack_top_entry,
    input wire logic [PC_W-1:0] stack_below,
    input wire rsc_pkg::rsc_phase_e phase_q,
    input wire logic flush_q,
    input wire logic busy
);
    logic [10:0] call_n;
    assign call_n = fetch.word[10:0];
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_push;
        phase_q == rsc_pkg::RSC_Q4 && fetch.valid && fetch.word == 16'h0005;
    endsequence
    sequence s_call;
        phase_q == rsc_pkg::RSC_Q4 && fetch.valid &&
            fetch.word[15:11] == 5'h1b;
    endsequence
    sequence s_flush;
        (flush_q && busy)[*4] ##1 !flush_q;
    endsequence
    property p_push_top;
        s_push |-> ##3 stack_top_entry == $past(pc_q);
    endproperty
    a_push_top: assert property (p_push_top)
        else $error("push top");
    property p_push_down;
        s_push |-> ##3 stack_below == $past(stack_top_entry);
    endproperty
    a_push_down: assert property (p_push_down)
        else $error("push down");
    property p_top_wr;
        top_wr && phase_q != rsc_pkg::RSC_Q2 |=>
            stack_top_entry == $past(top_wdata);
    endproperty
    a_top_wr: assert property (p_top_wr)
        else $error("top write");
    property p_call_push;
        s_call |-> ##3 stack_top_entry == $past(pc_q) && $stable(pc_q);
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("call push");
    property p_call_tgt;
        s_call |-> ##5 pc_q == $past(pc_q, 2) +
            PC_W'($signed({$past(call_n, 5), 1'b0}));
    endproperty
    a_call_tgt: assert property (p_call_tgt)
        else $error("call target");
    property p_call_flush;
        s_call |-> ##5 s_flush;
    endproperty
    a_call_flush: assert property (p_call_flush)
        else $error("call flush");
    property p_flush_pc;
        s_call |-> ##9 pc_q == $past(pc_q, 4) + PC_W'(2'h2);
    endproperty
    a_flush_pc: assert property (p_flush_pc)
        else $error("flush pc");
    property p_push_one;
        s_push |-> ##4 $stable(stack_top_entry) ##1
            !flush_q && pc_q == $past(pc_q, 2) + PC_W'(2'h2);
    endproperty
    a_push_one: assert property (p_push_one)
        else $error("push cycle");
endmodule
bind rsc_core rsc_core_monitor #(.PC_W(PC_W)) u_mon (.clk(clk), .nrst(nrst),
    .fetch(fetch), .top_wr(top_wr), .top_wdata(top_wdata), .pc_q(pc_q),
    .stack_top_entry(stack_top_entry), .stack_below(stack_below),
    .phase_q(phase_q), .flush_q(flush_q), .busy(busy));

// file: sim/tb_return_stack_push_rel_call.sv
// Purpose: Self-checking bench for push and relative call
// Assumes: Program counter steps by two on each Q4 edge, except where a call retargets it
// Notes: Each instruction is followed by idle cycles
`timescale 1ns/10ps
module tb_return_stack_push_rel_call;
    localparam int W = 21;
    logic clk = 0, nrst = 0, top_wr = 0, call_m = 0;
    logic [W-1:0] top_wdata = '0, pc_m = '0, tm = '0, bel = '0, tp = '0;
    logic [W-1:0] pc_q, stack_top_entry, stack_below, exp_q[$], want;
    logic [10:0] n_m = '0;
    logic [15:0] ws [7] = '{16'h0005, 16'hdc00, 16'h0005, 16'hdbff,
        16'h0006, 16'hd800, 16'h0005};
    logic flush_q, busy;
    rsc_pkg::rsc_fetch_s fetch = '0;
    rsc_pkg::rsc_phase_e phase_q;
    int mismatches = 0, compares = 0, seed = 86127, j;
    always #4 clk = ~clk;
    rsc_core dut (.clk(clk), .nrst(nrst), .fetch(fetch), .top_wr(top_wr),
        .top_wdata(top_wdata), .pc_q(pc_q), .stack_top_entry(stack_top_entry),
        .stack_below(stack_below), .phase_q(phase_q), .flush_q(flush_q),
        .busy(busy));
    task automatic check(string s, logic [W-1:0] seen, logic [W-1:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("Error %s expected %h seen %h", s, want, seen);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Reference program counter; a call retargets on the Q4 edge after the one that fetched it
    always @(posedge clk) begin
        if (nrst && phase_q == rsc_pkg::RSC_Q4) begin
            pc_m <= call_m ? pc_m + W'($signed({n_m, 1'b0})) : pc_m + 2;
            call_m <= fetch.valid && fetch.word[15:11] == 5'h1b;
            n_m <= fetch.word[10:0];
        end
    end
    // Any change of the top entry must match the oldest note
    always @(negedge clk) begin
        if (nrst && stack_top_entry !== tp) begin
            want = exp_q.size() ? exp_q.pop_front() : ~stack_top_entry;
            check("top", stack_top_entry, want);
        end
        tp = stack_top_entry;
    end
    task automatic op(logic [15:0] w);
        int i;
        for (i = 0; i < 9 && phase_q !== rsc_pkg::RSC_Q4; i++) @(negedge clk);
        if (i == 9) begin
            mismatches++;
            close_out();
        end
        fetch = {w, 1'b1};
        if (w == 16'h0005 || w[15:11] == 5'h1b) begin
            exp_q.push_back(pc_m + 2);
            bel = tm;
            tm = pc_m + 2;
        end
        @(negedge clk);
        fetch = '0;
        repeat (6) @(negedge clk);
        check("busy", busy, w[15:11] == 5'h1b);
        check("flush", flush_q, w[15:11] == 5'h1b);
        check("phase", phase_q, rsc_pkg::RSC_Q3);
        repeat (5) @(negedge clk);
        check("below", stack_below, bel);
        check("pc", pc_q, pc_m);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) nrst = 1;
        ws[5][10:0] = 11'($random(seed));
        for (j = 0; j < 7; j++) begin
            if (j % 4 == 2) begin
                top_wdata = W'($random(seed));
                top_wr = 1;
                exp_q.push_back(top_wdata);
                tm = top_wdata;
                @(negedge clk) top_wr = 0;
            end
            op(ws[j]);
        end
        check("notes", W'(exp_q.size()), '0);
        close_out();
    end
endmodule

// file: src/rsc_core.sv
// Purpose: Executes the stack-push and relative-call instructions
// Assumes: One instruction cycle is four clk phases Q1..Q4
// Notes: Other opcodes execute as no operation here
`timescale 1ns/10ps
`include "rsc_params.svh"

// Overview of operation
// [RULE1] Push opcode stores PC plus two on top
// [RULE2] Older top entry moves one level down
// [RULE3] Software may rewrite top, then push
// [RULE4] Relative call: 11011 prefix, signed 11-bit offset
// [RULE5] Relative call pushes return address first
// [RULE6] Doubled offset added to incremented PC
// [RULE7] Target is call address plus two plus 2n
// [RULE8] Relative call takes two cycles, second flushed
// [RULE9] Push is one cycle, written in Q2
module rsc_core #(
    parameter int PC_W = 21,
    parameter int DEPTH = `RSC_STACK_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Instruction fetch
    input wire rsc_pkg::rsc_fetch_s fetch,
    // Software write of the top entry
    input wire logic top_wr,
    input wire logic [PC_W-1:0] top_wdata,
    // Core state
    output logic [PC_W-1:0] pc_q,
    output logic [PC_W-1:0] stack_top_entry,
    output logic [PC_W-1:0] stack_below,
    output rsc_pkg::rsc_phase_e phase_q,
    output logic flush_q,
    output logic busy
);
    // ****************************************
    // Phase and state
    // ****************************************
    rsc_pkg::rsc_phase_e phase_d;
    rsc_pkg::rsc_state_e state_q;
    rsc_pkg::rsc_state_e state_d;
    logic [15:0] ir_q;
    logic ir_valid_q;
    logic [PC_W-1:0] stack_q [DEPTH];
    logic [PC_W-1:0] ret_addr;
    logic [PC_W-1:0] target;
    logic [PC_W-1:0] offset2;
    logic is_push;
    logic is_relative_call_op;
    logic do_push;
    logic [PC_W-1:0] pc_d;

    always_comb begin
        case (phase_q)
            rsc_pkg::RSC_Q1: phase_d = rsc_pkg::RSC_Q2;
            rsc_pkg::RSC_Q2: phase_d = rsc_pkg::RSC_Q3;
            rsc_pkg::RSC_Q3: phase_d = rsc_pkg::RSC_Q4;
            rsc_pkg::RSC_Q4: phase_d = rsc_pkg::RSC_Q1;
            default: phase_d = rsc_pkg::RSC_Q1;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= rsc_pkg::RSC_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ****************************************
    // Decode
    // ****************************************
    // Valid instruction latched at Q4 for the next cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ir_q <= 16'h0000;
            ir_valid_q <= 1'b0;
        end else if (phase_q == rsc_pkg::RSC_Q4) begin
            ir_q <= fetch.word;
            ir_valid_q <= fetch.valid;
        end
    end

    assign is_push = ir_valid_q && (ir_q == `RSC_PUSH_OPCODE); // [RULE1]
    assign is_relative_call_op = ir_valid_q && (ir_q[`RSC_RELATIVE_CALL_OP_TOP_MSB:
        `RSC_RELATIVE_CALL_OP_TOP_LSB] == `RSC_RELATIVE_CALL_OP_TOP); // [RULE4]
    // Sign-extend, then double: byte offset of word target
    assign offset2 = PC_W'({{(PC_W-11){ir_q[`RSC_OFFSET_MSB]}},
        ir_q[`RSC_OFFSET_MSB:0]} << 1); // [RULE4] [RULE6]
    // pc_q already points past the executing word
    assign ret_addr = pc_q; // [RULE5]
    assign target = ret_addr + offset2; // [RULE6] [RULE7]

    // Both opcodes push in Q2; flush cycle does not push
    assign do_push = (state_q == rsc_pkg::RSC_EXEC) &&
        (phase_q == rsc_pkg::RSC_Q2) && (is_push || is_relative_call_op); // [RULE9]

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            rsc_pkg::RSC_EXEC: begin
                if (phase_q == rsc_pkg::RSC_Q4 && is_relative_call_op) begin
                    state_d = rsc_pkg::RSC_FLUSH; // [RULE8]
                end
            end
            rsc_pkg::RSC_FLUSH: begin
                if (phase_q == rsc_pkg::RSC_Q4) begin
                    state_d = rsc_pkg::RSC_EXEC;
                end
            end
            default: state_d = rsc_pkg::RSC_EXEC;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= rsc_pkg::RSC_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    // Prefetched word is discarded during the flush cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= (state_d == rsc_pkg::RSC_FLUSH); // [RULE8]
        end
    end

    assign busy = (state_q == rsc_pkg::RSC_FLUSH);

    // ****************************************
    // Program counter
    // ****************************************
    // Only the Q4 edge moves the counter; flush cycle steps normally
    always_comb begin
        pc_d = pc_q;
        if (phase_q == rsc_pkg::RSC_Q4) begin
            if (state_q == rsc_pkg::RSC_EXEC && is_relative_call_op) begin
                pc_d = target; // [RULE5] [RULE7]
            end else begin
                pc_d = pc_q + PC_W'(`RSC_PC_STEP);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= PC_W'(`RSC_PC_RESET);
        end else begin
            pc_q <= pc_d;
        end
    end

    // ****************************************
    // Return stack
    // ****************************************
    // Overflow drops the deepest entry; no wrap detection here
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        if (i == 0) begin : g_top
            rsc_stack_cell #(.W(PC_W)) u_cell (
                .clk(clk),
                .nrst(nrst),
                .shift(do_push),
                .load(top_wr), // [RULE3]
                .shift_in(ret_addr), // [RULE1] [RULE5]
                .load_in(top_wdata),
                .q(stack_q[0])
            );
        end else begin : g_deep
            rsc_stack_cell #(.W(PC_W)) u_cell (
                .clk(clk),
                .nrst(nrst),
                .shift(do_push),
                .load(1'b0),
                .shift_in(stack_q[i-1]), // [RULE2]
                .load_in('0),
                .q(stack_q[i])
            );
        end
    end

    assign stack_top_entry = stack_q[0];
    assign stack_below = stack_q[1];
endmodule

// ****************************************
// One return-stack entry
// ****************************************
module rsc_stack_cell #(
    parameter int W = 21
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic shift,
    input wire logic load,
    // Data
    input wire logic [W-1:0] shift_in,
    input wire logic [W-1:0] load_in,
    output logic [W-1:0] q
);
    // Push wins over a software load on the same edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else if (shift) begin
            q <= shift_in;
        end else if (load) begin
            q <= load_in;
        end
    end
endmodule

// file: src/rsc_params.svh
// Purpose: Constants for the return-stack push / relative call executor
// Assumes: 16-bit instruction words, byte-addressed program counter
// Notes: Opcode patterns, field positions, PC step and reset value, stack depth
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH

`define RSC_PUSH_OPCODE 16'h0005
`define RSC_RELATIVE_CALL_OP_TOP 5'h1b
`define RSC_RELATIVE_CALL_OP_TOP_MSB 15
`define RSC_RELATIVE_CALL_OP_TOP_LSB 11
`define RSC_OFFSET_MSB 10
`define RSC_PC_STEP 21'h000002
`define RSC_PC_RESET 21'h000000
`define RSC_STACK_DEPTH 31

`endif

// file: src/rsc_pkg.sv
// Purpose: Types for the return-stack push / relative call executor
// Assumes: Constants live in rsc_params.svh
// Notes: Phase and state enums, fetch struct
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_Q1,
        RSC_Q2,
        RSC_Q3,
        RSC_Q4
    } rsc_phase_e;

    typedef enum logic {
        RSC_EXEC,
        RSC_FLUSH
    } rsc_state_e;

    typedef struct packed {
        logic [15:0] word;
        logic valid;
    } rsc_fetch_s;
endpackage
